// ===== core/uac_params.svh
// Purpose: constants of the universal analog comparator element
// Assumes: values in milli units of their quantity, thresholds in milli per-unit
// Notes:   included by the package and both modules
`ifndef UAC_PARAMS_SVH
`define UAC_PARAMS_SVH

// clock and processing tick
`define UAC_CLK_PERIOD_NS   8
`define UAC_TICK_TIME_NS    1000000
// time unit lengths, in millisecond ticks
`define UAC_UNIT_MS_TICKS   17'h00001
`define UAC_UNIT_S_TICKS    17'h003E8
`define UAC_UNIT_MIN_TICKS  17'h0EA60
// delta interval count range
`define UAC_INTERVAL_MIN    17'h00014
`define UAC_INTERVAL_MAX    17'h15180
// threshold range, milli per-unit (plus or minus 90.000 pu)
`define UAC_PICKUP_MAX      18'sh15F90
`define UAC_PICKUP_MIN      (-18'sh15F90)
// hysteresis range, tenths of a percent (0.1 to 50.0 %)
`define UAC_HYST_MIN        9'h001
`define UAC_HYST_MAX        9'h1F4
// scale of one milli unit
`define UAC_MILLI           1000
// fixed per-unit bases, in milli units of the quantity
`define UAC_BASE_FREQ       32'h000003E8
`define UAC_BASE_ANGLE      32'h00057E40
`define UAC_BASE_PF         32'h000003E8
`define UAC_BASE_RTD        32'h000186A0
`define UAC_BASE_ENERGY     32'h00989680
`define UAC_BASE_ARC        32'h001E8480
// reset values
`define UAC_OP_RESET        '0

`endif

// ===== core/uac_pkg.sv
// Purpose: types shared by the comparator element modules
// Assumes: constants come from uac_params.svh
// Notes:   enums carry no explicit codes
`include "uac_params.svh"

package uac_pkg;
  // input value and operating signal widths
  typedef logic signed [31:0] uac_val_t;
  typedef logic signed [33:0] uac_op_t;
  typedef logic signed [79:0] uac_wide_t;
  // measured quantity type of a selected input
  typedef enum logic [3:0] {
    QT_CURRENT, QT_VOLTAGE, QT_POWER, QT_FREQ, QT_ANGLE,
    QT_PF, QT_RTD, QT_ENERGY, QT_ARC, QT_DCMA
  } uac_qty_t;
  // signed or absolute input mode
  typedef enum logic {IM_SIGNED, IM_ABSOLUTE} uac_in_mode_t;
  // level or delta comparison
  typedef enum logic {CM_LEVEL, CM_DELTA} uac_comp_mode_t;
  // pickup direction
  typedef enum logic {DIR_OVER, DIR_UNDER} uac_dir_t;
  // unit of the delta interval
  typedef enum logic [1:0] {TU_MS, TU_SEC, TU_MIN} uac_time_unit_t;
endpackage : uac_pkg

// ===== core/uac_delta_if.sv
// Purpose: carries the operating signal to the delta stage and back
// Assumes: one clock domain
// Notes:   restart clears the interval history
`timescale 1ns/1ns

interface uac_delta_if;
  import uac_pkg::*;
  logic           tick;                // millisecond processing tick
  logic           restart;             // element inoperative, clear history
  uac_op_t        op_sig;              // operating signal after input mode
  uac_comp_mode_t comp_mode;           // level or delta
  uac_time_unit_t interval_time_unit;  // unit of the interval
  logic [16:0]    interval_count;      // interval length in units
  uac_op_t        op_cmp;              // signal handed to the comparator

  modport core  (output tick, restart, op_sig, comp_mode, interval_time_unit,
                 interval_count, input op_cmp);
  modport delta (input tick, restart, op_sig, comp_mode, interval_time_unit,
                 interval_count, output op_cmp);
endinterface : uac_delta_if

// ===== core/uac_delta.sv
// Purpose: level pass-through or change of the operating signal over an interval
// Assumes: tick is one cycle wide, once per millisecond
// Notes:   the change is refreshed at the end of each interval
`timescale 1ns/1ns
`include "uac_params.svh"

module uac_delta (
  input wire logic clk,
  input wire logic rst,
  uac_delta_if.delta dif
);
  import uac_pkg::*;

  logic [16:0] unit_len;    // ticks per time unit
  logic [16:0] count_eff;   // interval count clamped to range
  logic [16:0] unit_cnt_q;  // ticks within the current unit
  logic [16:0] int_cnt_q;   // units within the current interval
  logic        unit_end;    // last tick of a unit
  logic        int_end;     // last tick of an interval
  uac_op_t     snap_q;      // signal at the start of the interval
  uac_op_t     delta_q;     // change over the last full interval

  // unit length from the selected time unit
  always_comb begin
    unique case (dif.interval_time_unit)
      TU_SEC:  unit_len = `UAC_UNIT_S_TICKS;
      TU_MIN:  unit_len = `UAC_UNIT_MIN_TICKS;
      default: unit_len = `UAC_UNIT_MS_TICKS;
    endcase
  end

  // interval count held to its legal range
  always_comb begin
    if (dif.interval_count < `UAC_INTERVAL_MIN) begin
      count_eff = `UAC_INTERVAL_MIN;
    end else if (dif.interval_count > `UAC_INTERVAL_MAX) begin
      count_eff = `UAC_INTERVAL_MAX;
    end else begin
      count_eff = dif.interval_count;
    end
  end

  assign unit_end = dif.tick && (unit_cnt_q == unit_len - 17'h00001);
  assign int_end  = unit_end && (int_cnt_q == count_eff - 17'h00001);

  // tick counter inside one unit
  always_ff @(posedge clk) begin
    if (rst || dif.restart || dif.comp_mode == CM_LEVEL) begin
      unit_cnt_q <= '0;
    end else if (unit_end) begin
      unit_cnt_q <= '0;
    end else if (dif.tick) begin
      unit_cnt_q <= unit_cnt_q + 17'h00001;
    end
  end

  // unit counter inside one interval
  always_ff @(posedge clk) begin
    if (rst || dif.restart || dif.comp_mode == CM_LEVEL) begin
      int_cnt_q <= '0;
    end else if (int_end) begin
      int_cnt_q <= '0;
    end else if (unit_end) begin
      int_cnt_q <= int_cnt_q + 17'h00001;
    end
  end

  // snapshot and change over the interval
  always_ff @(posedge clk) begin
    if (rst) begin
      snap_q  <= `UAC_OP_RESET;
      delta_q <= `UAC_OP_RESET;
    end else if (dif.restart || dif.comp_mode == CM_LEVEL) begin
      snap_q  <= dif.op_sig;
      delta_q <= `UAC_OP_RESET;
    end else if (int_end) begin
      snap_q  <= dif.op_sig;
      delta_q <= dif.op_sig - snap_q;
    end
  end

  // level mode passes the signal, delta mode the change
  assign dif.op_cmp = (dif.comp_mode == CM_DELTA) ? delta_q : dif.op_sig;

  property p_level_pass;
    @(posedge clk) disable iff (rst)
      dif.comp_mode == CM_LEVEL |-> dif.op_cmp == dif.op_sig
        ##1 (delta_q == '0 && int_cnt_q == '0 && unit_cnt_q == '0);
  endproperty
  a_level_pass: assert property (p_level_pass) else $error("level mode altered signal");

  property p_delta_update;
    @(posedge clk) disable iff (rst)
      int_end && !dif.restart && dif.comp_mode == CM_DELTA
        |=> delta_q == $past(dif.op_sig) - $past(snap_q);
  endproperty
  a_delta_update: assert property (p_delta_update) else $error("delta not refreshed");
endmodule : uac_delta

// ===== core/uac_core.sv
// Purpose: universal analog comparator element with delay timers
// Assumes: inputs synchronous to clk; settings stable between changes
// Notes:   evaluation happens once per millisecond tick
`timescale 1ns/1ns
`include "uac_params.svh"

// What this block does
// - off selector contributes zero
// - operating signal is first minus second
// - both selectors off never asserts operate or picked, only inoperative
// - mismatched quantity types keep element inoperative
// - signed uses difference, absolute uses magnitude
// - level compares signal, delta compares change
// - interval 20 to 86400 in ms, s, min
// - interval settings matter only in delta mode
// - over picks up above, under below
// - signed threshold within plus minus 90 pu
// - hysteresis band is percent of threshold
// - output asserts after pickup delay held
// - output drops after reset delay held
// - fixed bases for frequency, angle, PF, temperature
// - current, voltage, power use larger nominal base
// - fixed bases for energy and arcing current
// - transducer base is larger range maximum
module uac_core #(
  parameter int unsigned TICK_CYCLES = `UAC_TICK_TIME_NS / `UAC_CLK_PERIOD_NS
) (
  input  wire logic                    clk,
  input  wire logic                    rst,
  input  wire logic                    element_enable,
  input  wire logic                    inhibit_input,
  input  wire logic                    pos_sel_off,
  input  wire uac_pkg::uac_qty_t       pos_type,
  input  wire uac_pkg::uac_val_t       pos_value,
  input  wire logic [31:0]             pos_nominal_base,
  input  wire logic [31:0]             pos_transducer_range_max,
  input  wire logic                    neg_sel_off,
  input  wire uac_pkg::uac_qty_t       neg_type,
  input  wire uac_pkg::uac_val_t       neg_value,
  input  wire logic [31:0]             neg_nominal_base,
  input  wire logic [31:0]             neg_transducer_range_max,
  input  wire uac_pkg::uac_in_mode_t   input_mode,
  input  wire uac_pkg::uac_comp_mode_t comp_mode,
  input  wire uac_pkg::uac_dir_t       direction,
  input  wire logic signed [17:0]      pickup_threshold,
  input  wire logic [8:0]              hysteresis_permille,
  input  wire uac_pkg::uac_time_unit_t interval_time_unit,
  input  wire logic [16:0]             interval_count,
  input  wire logic [15:0]             assert_delay,
  input  wire logic [15:0]             reset_delay,
  output      logic                    comparator_picked,
  output      logic                    element_operate,
  output      logic                    element_inoperative
);
  import uac_pkg::*;

  localparam int TW = $clog2(TICK_CYCLES);

  uac_delta_if dif ();                     // link to the delta stage

  logic [TW-1:0]      tick_cnt_q;          // cycles within one millisecond
  logic               tick;                // one-cycle processing tick
  logic               inop;                // element cannot operate
  uac_op_t            pos_term;            // first input or zero
  uac_op_t            neg_term;            // second input or zero
  uac_op_t            diff;                // signed difference
  uac_op_t            op_sig;              // after input mode
  logic [31:0]        base;                // per-unit base, milli units
  logic signed [17:0] pk_eff;              // clamped threshold
  logic [8:0]         hyst_eff;            // clamped hysteresis
  uac_wide_t          lhs;                 // signal scaled for comparison
  uac_wide_t          rhs_pu;              // threshold times base
  uac_wide_t          rhs;                 // pickup point, same scale as lhs
  uac_wide_t          band;                // hysteresis band, same scale
  logic               cmp_next;            // comparator state for this tick
  logic               picked_q;            // comparator picked up
  logic               operate_q;           // element output
  logic               inop_q;              // registered inoperative status
  logic [15:0]        pk_cnt_q;            // ms held picked up
  logic [15:0]        rs_cnt_q;            // ms held dropped out

  // larger of two bases
  function automatic logic [31:0] max32(input logic [31:0] a, input logic [31:0] b);
    max32 = (a > b) ? a : b;
  endfunction : max32

  // millisecond tick from the system clock
  always_ff @(posedge clk) begin
    if (rst || tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TW'(1);
    end
  end
  assign tick = (tick_cnt_q == TW'(TICK_CYCLES - 1));

  // element is inoperative when disabled, inhibited or ill-configured
  assign inop = !element_enable || inhibit_input
             || (pos_sel_off && neg_sel_off)
             || (!pos_sel_off && !neg_sel_off && pos_type != neg_type);

  // operating signal: first input minus second, off reads zero
  always_comb begin
    pos_term = pos_sel_off ? uac_op_t'(0) : uac_op_t'(pos_value);
    neg_term = neg_sel_off ? uac_op_t'(0) : uac_op_t'(neg_value);
    diff     = pos_term - neg_term;
    if (input_mode == IM_ABSOLUTE && diff < 0) begin
      op_sig = -diff;
    end else begin
      op_sig = diff;
    end
  end

  // per-unit base from the type of the selected inputs
  always_comb begin
    unique case (pos_sel_off ? neg_type : pos_type)
      QT_FREQ:   base = `UAC_BASE_FREQ;
      QT_ANGLE:  base = `UAC_BASE_ANGLE;
      QT_PF:     base = `UAC_BASE_PF;
      QT_RTD:    base = `UAC_BASE_RTD;
      QT_ENERGY: base = `UAC_BASE_ENERGY;
      QT_ARC:    base = `UAC_BASE_ARC;
      QT_DCMA:   base = max32(pos_sel_off ? 32'h0 : pos_transducer_range_max,
                              neg_sel_off ? 32'h0 : neg_transducer_range_max);
      // current, voltage and power carry their base on the nominal ports
      default:   base = max32(pos_sel_off ? 32'h0 : pos_nominal_base,
                              neg_sel_off ? 32'h0 : neg_nominal_base);
    endcase
  end

  // settings held within their legal ranges
  always_comb begin
    if (pickup_threshold > `UAC_PICKUP_MAX) begin
      pk_eff = `UAC_PICKUP_MAX;
    end else if (pickup_threshold < `UAC_PICKUP_MIN) begin
      pk_eff = `UAC_PICKUP_MIN;
    end else begin
      pk_eff = pickup_threshold;
    end
    if (hysteresis_permille < `UAC_HYST_MIN) begin
      hyst_eff = `UAC_HYST_MIN;
    end else if (hysteresis_permille > `UAC_HYST_MAX) begin
      hyst_eff = `UAC_HYST_MAX;
    end else begin
      hyst_eff = hysteresis_permille;
    end
  end

  // delta stage hookup
  assign dif.tick               = tick;
  assign dif.restart            = inop;
  assign dif.op_sig             = op_sig;
  assign dif.comp_mode          = comp_mode;
  assign dif.interval_time_unit = interval_time_unit;
  assign dif.interval_count     = interval_count;

  uac_delta u_delta (
    .clk (clk),
    .rst (rst),
    .dif (dif)
  );

  // all terms scaled to milli-unit times milli-per-unit times thousand
  always_comb begin
    lhs    = uac_wide_t'(dif.op_cmp) * uac_wide_t'(`UAC_MILLI)
             * uac_wide_t'(`UAC_MILLI);
    rhs_pu = uac_wide_t'(pk_eff) * uac_wide_t'(base);
    rhs    = rhs_pu * uac_wide_t'(`UAC_MILLI);
    band   = ((rhs_pu < 0) ? -rhs_pu : rhs_pu) * uac_wide_t'(hyst_eff);
  end

  // comparator with direction and hysteresis, signed compares throughout
  always_comb begin
    if (direction == DIR_OVER) begin
      cmp_next = picked_q ? (lhs >= rhs - band) : (lhs > rhs);
    end else begin
      cmp_next = picked_q ? (lhs <= rhs + band) : (lhs < rhs);
    end
  end

  // comparator state, updated once per tick
  always_ff @(posedge clk) begin
    if (rst || inop) begin
      picked_q <= 1'b0;
    end else if (tick) begin
      picked_q <= cmp_next;
    end
  end

  // pickup delay timer in ms
  always_ff @(posedge clk) begin
    if (rst || inop) begin
      pk_cnt_q <= '0;
    end else if (tick) begin
      if (!cmp_next || operate_q) begin
        pk_cnt_q <= '0;
      end else if (pk_cnt_q < assert_delay) begin
        pk_cnt_q <= pk_cnt_q + 16'h0001;
      end
    end
  end

  // reset delay timer in ms
  always_ff @(posedge clk) begin
    if (rst || inop) begin
      rs_cnt_q <= '0;
    end else if (tick) begin
      if (cmp_next || !operate_q) begin
        rs_cnt_q <= '0;
      end else if (rs_cnt_q < reset_delay) begin
        rs_cnt_q <= rs_cnt_q + 16'h0001;
      end
    end
  end

  // element output
  always_ff @(posedge clk) begin
    if (rst || inop) begin
      operate_q <= 1'b0;
    end else if (tick) begin
      if (cmp_next && !operate_q && pk_cnt_q >= assert_delay) begin
        operate_q <= 1'b1;
      end else if (!cmp_next && operate_q && rs_cnt_q >= reset_delay) begin
        operate_q <= 1'b0;
      end
    end
  end

  // inoperative status
  always_ff @(posedge clk) begin
    if (rst) begin
      inop_q <= 1'b1;
    end else begin
      inop_q <= inop;
    end
  end

  assign comparator_picked   = picked_q;
  assign element_operate     = operate_q;
  assign element_inoperative = inop_q;

  property p_off_zero;
    @(posedge clk) disable iff (rst)
      pos_sel_off && !neg_sel_off |-> diff == -uac_op_t'(neg_value);
  endproperty
  a_off_zero: assert property (p_off_zero) else $error("off input not zero");

  property p_both_off;
    @(posedge clk) disable iff (rst)
      pos_sel_off && neg_sel_off |=> !operate_q && !picked_q;
  endproperty
  a_both_off: assert property (p_both_off) else $error("output with both inputs off");

  property p_type_mismatch;
    @(posedge clk) disable iff (rst)
      !pos_sel_off && !neg_sel_off && pos_type != neg_type |=> !operate_q && inop_q;
  endproperty
  a_type_mismatch: assert property (p_type_mismatch) else $error("mismatched types operated");

  property p_abs_mode;
    @(posedge clk) disable iff (rst)
      input_mode == IM_ABSOLUTE |-> op_sig >= 0 && (op_sig == diff || op_sig == -diff);
  endproperty
  a_abs_mode: assert property (p_abs_mode) else $error("absolute mode sign wrong");

  property p_over_pickup;
    @(posedge clk) disable iff (rst)
      tick && !inop && direction == DIR_OVER && lhs > rhs |=> picked_q;
  endproperty
  a_over_pickup: assert property (p_over_pickup) else $error("over did not pick up");

  property p_under_pickup;
    @(posedge clk) disable iff (rst)
      tick && !inop && direction == DIR_UNDER && lhs < rhs |=> picked_q;
  endproperty
  a_under_pickup: assert property (p_under_pickup) else $error("under did not pick up");

  property p_assert_delay;
    @(posedge clk) disable iff (rst)
      $rose(operate_q) |-> $past(pk_cnt_q) >= $past(assert_delay) && picked_q;
  endproperty
  a_assert_delay: assert property (p_assert_delay) else $error("output rose early");

  property p_reset_delay;
    @(posedge clk) disable iff (rst)
      $fell(operate_q) && !$past(inop) |-> $past(rs_cnt_q) >= $past(reset_delay) && !picked_q;
  endproperty
  a_reset_delay: assert property (p_reset_delay) else $error("output fell early");

  property p_inhibit;
    @(posedge clk) disable iff (rst)
      inhibit_input |=> !operate_q && pk_cnt_q == 16'h0000 && rs_cnt_q == 16'h0000;
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("inhibit did not clear");

  sequence s_tick;
    tick;
  endsequence
  property p_tick_spacing;
    @(posedge clk) disable iff (rst)
      s_tick |=> !tick [*8];
  endproperty
  a_tick_spacing: assert property (p_tick_spacing) else $error("ticks too close");
endmodule : uac_core

// ===== verif/tb.sv
// Purpose: self-checking bench of the comparator element
// Assumes: short tick of ten clocks, delays counted in ticks
// Notes:   random level cases plus hand-written corner cases
`timescale 1ns/1ns
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end

module tb;
  import uac_pkg::*;
  localparam int TC = 10;  // clocks per tick
  logic           clk, rst, element_enable, inhibit_input, pos_sel_off, neg_sel_off;
  uac_qty_t       pos_type, neg_type;
  uac_val_t       pos_value, neg_value;
  logic [31:0]    pos_nominal_base, neg_nominal_base;
  logic [31:0]    pos_transducer_range_max, neg_transducer_range_max;
  uac_in_mode_t   input_mode;
  uac_comp_mode_t comp_mode;
  uac_dir_t       direction;
  logic signed [17:0] pickup_threshold;
  logic [8:0]     hysteresis_permille;
  uac_time_unit_t interval_time_unit;
  logic [16:0]    interval_count;
  logic [15:0]    assert_delay, reset_delay;
  logic           comparator_picked, element_operate, element_inoperative;
  int             mismatches, comparisons, cyc;

  uac_core #(.TICK_CYCLES(TC)) uut (.clk, .rst, .element_enable, .inhibit_input,
    .pos_sel_off, .pos_type, .pos_value, .pos_nominal_base, .pos_transducer_range_max,
    .neg_sel_off, .neg_type, .neg_value, .neg_nominal_base, .neg_transducer_range_max,
    .input_mode, .comp_mode, .direction, .pickup_threshold, .hysteresis_permille,
    .interval_time_unit, .interval_count, .assert_delay, .reset_delay,
    .comparator_picked, .element_operate, .element_inoperative);

  // clock of 8 ns
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // cut a hang short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      mismatches++;
      finish_test();
    end
  end

  task automatic finish_test();
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : finish_test

  // per-unit base in milli units, larger of the selected inputs where it depends on them
  function automatic longint base_of(uac_qty_t t);
    longint a, b;
    a = pos_sel_off ? 0 : (t == QT_DCMA ? pos_transducer_range_max : pos_nominal_base);
    b = neg_sel_off ? 0 : (t == QT_DCMA ? neg_transducer_range_max : neg_nominal_base);
    case (t)
      QT_FREQ, QT_PF: return 1000;
      QT_ANGLE:       return 360000;
      QT_RTD:         return 100000;
      QT_ENERGY:      return 10000000;
      QT_ARC:         return 2000000;
      default:        return (a > b) ? a : b;
    endcase
  endfunction : base_of

  // pickup from a cleared state, no hysteresis involved
  function automatic logic exp_pick();
    longint d, r;
    d = (pos_sel_off ? 0 : longint'(pos_value)) - (neg_sel_off ? 0 : longint'(neg_value));
    if (input_mode == IM_ABSOLUTE && d < 0) d = -d;
    r = longint'(pickup_threshold) * base_of(pos_sel_off ? neg_type : pos_type);
    return (direction == DIR_OVER) ? (d * 1000 > r) : (d * 1000 < r);
  endfunction : exp_pick

  // wait on picked (op=0) or operate (op=1), counting falling edges
  task automatic wait_lvl(input bit op, input logic v, output int c);
    c = 0;
    while (((op ? element_operate : comparator_picked) !== v) && c < 3000) begin
      @(negedge clk);
      c++;
    end
  endtask : wait_lvl

  // plain level set-up on a frequency input, state cleared by inhibit
  task automatic setup(uac_dir_t dr, int thr, int h);
    @(posedge clk);
    inhibit_input <= 1'b1;
    {pos_sel_off, neg_sel_off} <= 2'b01;
    pos_type <= QT_FREQ;
    neg_type <= QT_FREQ;
    input_mode <= IM_SIGNED;
    comp_mode <= CM_LEVEL;
    direction <= dr;
    pickup_threshold <= 18'(thr);
    hysteresis_permille <= 9'(h);
    {assert_delay, reset_delay} <= '0;
    @(posedge clk);
    inhibit_input <= 1'b0;
  endtask : setup

  // apply a value and let three ticks pass
  task automatic hold(int v);
    @(posedge clk);
    pos_value <= v;
    repeat (3 * TC) @(posedge clk);
    @(negedge clk);
  endtask : hold

  task automatic rnd_case(int i);
    logic e;
    @(posedge clk);
    inhibit_input <= 1'b1;
    pos_type <= uac_qty_t'(i % 10);
    neg_type <= uac_qty_t'(i % 10);
    pos_sel_off <= (i % 3 == 1);
    neg_sel_off <= (i % 3 == 2);
    pos_value <= int'($urandom_range(2000000)) - 1000000;
    neg_value <= int'($urandom_range(2000000)) - 1000000;
    pos_nominal_base <= 32'($urandom_range(20000, 1000));
    neg_nominal_base <= 32'($urandom_range(20000, 1000));
    pos_transducer_range_max <= 32'($urandom_range(20000, 1000));
    neg_transducer_range_max <= 32'($urandom_range(20000, 1000));
    input_mode <= uac_in_mode_t'($urandom_range(1));
    direction <= uac_dir_t'($urandom_range(1));
    pickup_threshold <= (i < 2) ? (i ? 18'sh15F90 : -18'sh15F90)
                                : 18'(int'($urandom_range(180000)) - 90000);
    hysteresis_permille <= 9'($urandom_range(500, 1));
    interval_time_unit <= uac_time_unit_t'($urandom_range(2));
    interval_count <= 17'($urandom_range(86400, 20));
    @(posedge clk);
    inhibit_input <= 1'b0;
    repeat (4 * TC) @(posedge clk);
    @(negedge clk);
    e = exp_pick();
    `CHK("picked", e, comparator_picked)
    `CHK("operate", e, element_operate)
    `CHK("inop", 1'b0, element_inoperative)
  endtask : rnd_case

  task automatic hys(uac_dir_t dr, int thr, int h, int v1, int v2, int v3);
    setup(dr, thr, h);
    hold(v1);
    `CHK("hys_pick", 1'b1, comparator_picked)
    hold(v2);
    `CHK("hys_band", 1'b1, comparator_picked)
    hold(v3);
    `CHK("hys_drop", 1'b0, comparator_picked)
  endtask : hys

  task automatic delays(int d, int r);
    int c;
    setup(DIR_OVER, 1000, 30);
    {assert_delay, reset_delay} <= {16'(d), 16'(r)};
    pos_value <= 2000;
    @(negedge clk);
    wait_lvl(0, 1'b1, c);
    wait_lvl(1, 1'b1, c);
    `CHK("rise_cyc", d * TC, c)
    @(posedge clk);
    pos_value <= 0;
    wait_lvl(0, 1'b0, c);
    wait_lvl(1, 1'b0, c);
    `CHK("fall_cyc", r * TC, c)
    @(posedge clk);
    pos_value <= 2000;
    @(negedge clk);
    wait_lvl(1, 1'b1, c);
    @(posedge clk);
    inhibit_input <= 1'b1;
    repeat (2) @(negedge clk);
    `CHK("inh_op", 1'b0, element_operate)
    `CHK("inh_inop", 1'b1, element_inoperative)
    @(posedge clk);
    inhibit_input <= 1'b0;
    @(negedge clk);
    wait_lvl(0, 1'b1, c);
    wait_lvl(1, 1'b1, c);
    `CHK("rerise_cyc", d * TC, c)
    @(posedge clk);
    element_enable <= 1'b0;
    repeat (2) @(negedge clk);
    `CHK("dis_op", 1'b0, element_operate)
    `CHK("dis_pick", 1'b0, comparator_picked)
    @(posedge clk);
    element_enable <= 1'b1;
  endtask : delays

  initial begin
    int c;
    void'($urandom(32'h597cd8b9));
    {rst, element_enable, inhibit_input, pos_sel_off, neg_sel_off} = 5'b11000;
    pos_type = QT_CURRENT;
    neg_type = QT_CURRENT;
    {pos_value, neg_value} = '0;
    {pos_nominal_base, neg_nominal_base} = '0;
    {pos_transducer_range_max, neg_transducer_range_max} = '0;
    input_mode = IM_SIGNED;
    comp_mode = CM_LEVEL;
    direction = DIR_OVER;
    {pickup_threshold, hysteresis_permille} = '0;
    interval_time_unit = TU_MS;
    {interval_count, assert_delay, reset_delay} = '0;
    // reset is released on the sixteenth edge
    repeat (15) @(posedge clk);
    @(negedge clk);
    `CHK("rst_pick", 1'b0, comparator_picked)
    `CHK("rst_inop", 1'b1, element_inoperative)
    @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 40; i++) rnd_case(i);
    hys(DIR_OVER, 1000, 30, 2000, 980, 960);
    hys(DIR_UNDER, -1000, 100, -2000, -950, -850);
    delays(3, 2);
    // mismatched types, then both selectors off, with a signal that would pick
    setup(DIR_OVER, -1000, 30);
    neg_sel_off <= 1'b0;
    neg_type <= QT_ANGLE;
    pos_value <= 32'sh000007D0;
    repeat (4 * TC) @(negedge clk);
    `CHK("mix_pick", 1'b0, comparator_picked)
    `CHK("mix_inop", 1'b1, element_inoperative)
    @(posedge clk);
    {pos_sel_off, neg_sel_off} <= 2'b11;
    repeat (4 * TC) @(negedge clk);
    `CHK("off_op", 1'b0, element_operate)
    // delta over the shortest interval: a steady level gives no change
    setup(DIR_OVER, 1000, 30);
    comp_mode <= CM_DELTA;
    interval_time_unit <= TU_MS;
    interval_count <= 17'h00014;
    pos_value <= 5000;
    repeat (50 * TC) @(negedge clk);
    `CHK("dlt_flat", 1'b0, comparator_picked)
    @(posedge clk);
    pos_value <= 7000;
    wait_lvl(0, 1'b1, c);
    `CHK("dlt_step", 1'b1, comparator_picked)
    repeat (10 * TC) @(negedge clk);
    `CHK("dlt_hold", 1'b1, comparator_picked)
    repeat (12 * TC) @(negedge clk);
    `CHK("dlt_next", 1'b0, comparator_picked)
    finish_test();
  end
endmodule : tb
